//--- rtl/spm_ctrl.sv
// Self-programming sequencer with AXI4-Lite register access.
// Assumes CPU store/load program strobes arrive synchronous to mclk_i and
// that the flash array honours rww_block_o and the programming pulses.
//
// Function
// - Block reads of the read-while-write section during erase or write.
// - Busy flag stays set while that section is busy or blocked.
// - Lock set is data byte, pattern X0001001, store within four cycles.
// - Zero data bits 5:0 program matching lock bits, only inside window.
// - Address pointer ignored during lock-bit setting.
// - Whole flash stays readable while lock bits are programmed.
// - EEPROM write busy rejects programming and fuse or lock reads.
// - Pointer 0x0001 with lock-set and enable returns lock bits on load.
// - Lock-set and enable clear on read, load timeout or store timeout.
// - With both bits clear, load performs a normal memory byte read.
// - Pointer 0x0000, 0x0003, 0x0002 select fuse low, high, extended.
// - Extended fuse byte carries only bits 2 to 0.
// - Programmed bits read zero, unprogrammed bits read one.
// - Erase, write and lock programming last 3.7 ms to 4.5 ms.
// - A started flash write completes even through a reset; here reset returns the sequencer to idle and clears its timer.
// - Enable bit opens store for four cycles, clears after one or expiry.
// - Page erase is pattern X0000011 then store within four cycles.
// - Page write is pattern X0000101 then store within four cycles.
// - Busy flag set on erase or write to section, cleared by re-enable.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module spm_ctrl #(
  parameter int PROG_CYCLES = spm_ctrl_pkg::PROG_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // CPU instruction strobes
  input  wire logic        store_prog_i,
  input  wire logic        load_prog_i,
  input  wire logic [15:0] addr_ptr_i,
  input  wire logic [7:0]  data_low_i,
  input  wire logic [7:0]  flash_byte_i,
  input  wire logic        eeprom_write_busy_i,
  // Flash side
  output logic [7:0]       load_data_o,
  output logic             load_valid_o,
  output logic             rww_block_o,
  output logic             erase_start_o,
  output logic             write_start_o,
  output logic [15:0]      page_addr_o,
  output logic             flash_busy_o
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  // Timer needs at least two counts to raise a done pulse
  if (PROG_CYCLES < 2) begin : g_bad_prog
    $error("PROG_CYCLES too small");
  end

  // Reset release synchroniser
  logic rst_meta, rst_sync_n;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // EEPROM busy is a foreign level: two flops first
  logic ee_meta, ee_busy;
  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ee_meta <= 1'b0;
      ee_busy <= 1'b0;
    end else begin
      ee_meta <= eeprom_write_busy_i;
      ee_busy <= ee_meta;
    end
  end

  // Control state
  spm_ctrl_pkg::seq_state_e state;
  logic [4:0] cmd;          // rwwre, lock_bit_set_cmd, page_write_cmd, page_erase_cmd, store_prog_enable
  logic       rww_busy;
  logic [7:0] lock_bits;
  logic [7:0] fuse_low, fuse_high, fuse_ext;
  logic [2:0] win_cnt;
  logic       op_rww, op_lock;
  logic [7:0] lock_pend;

  // Programming timer on the synchronised reset
  logic       prog_load, prog_done, prog_run;
  spm_window_timer #(.WIDTH(TW)) u_prog_timer (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_sync_n),
    .load_i   (prog_load),
    .count_i  (TW'(PROG_CYCLES)),
    .done_o   (prog_done),
    .running_o(prog_run)
  );

  // AXI write channel decode
  logic aw_held, w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire  wr_fire   = aw_held && w_held && !s_axi_bvalid;
  wire  ctrl_wr   = wr_fire && (aw_addr == spm_ctrl_pkg::CTRL_OFFS) && w_strb[0];
  wire  wr_mapped = (aw_addr == spm_ctrl_pkg::CTRL_OFFS) || (aw_addr == spm_ctrl_pkg::LOCK_OFFS) ||
                    (aw_addr == spm_ctrl_pkg::FLOW_OFFS) || (aw_addr == spm_ctrl_pkg::FHIGH_OFFS) ||
                    (aw_addr == spm_ctrl_pkg::FEXT_OFFS);
  // Command accepted only when idle and EEPROM quiet
  wire  cmd_ok    = ctrl_wr && (state == spm_ctrl_pkg::ST_IDLE) && !ee_busy &&
                    w_data[spm_ctrl_pkg::ENABLE_BIT];
  wire  armed     = (state == spm_ctrl_pkg::ST_ARMED);
  wire  win_end   = armed && (win_cnt == 3'(spm_ctrl_pkg::SPM_WIN_CYC - 1));
  wire  spm_hit   = armed && store_prog_i && !ee_busy;
  wire  is_erase  = cmd[1] && !cmd[2] && !cmd[3];
  wire  is_write  = cmd[2] && !cmd[1] && !cmd[3];
  wire  is_lock   = cmd[3] && !cmd[1] && !cmd[2];
  wire  is_rwwre  = cmd[4];
  wire  lpm_win   = armed && is_lock && (win_cnt < 3'(spm_ctrl_pkg::LPM_WIN_CYC));
  wire  lpm_fuse  = lpm_win && load_prog_i && !ee_busy;
  wire  in_rww    = addr_ptr_i[15:1] < spm_ctrl_pkg::RWW_LIMIT;
  wire  page_op   = spm_hit && (is_erase || is_write);
  assign prog_load = page_op || (spm_hit && is_lock);

  // Fuse byte selection by pointer
  logic [7:0] fuse_sel;
  always_comb begin
    case (addr_ptr_i)
      spm_ctrl_pkg::Z_FLOW:  fuse_sel = fuse_low;
      spm_ctrl_pkg::Z_LOCK:  fuse_sel = lock_bits;
      spm_ctrl_pkg::Z_FEXT:  fuse_sel = {5'h1f, fuse_ext[2:0]};
      spm_ctrl_pkg::Z_FHIGH: fuse_sel = fuse_high;
      default:               fuse_sel = 8'hff;
    endcase
  end

  // Sequencer
  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state   <= spm_ctrl_pkg::ST_IDLE;
      cmd     <= 5'h00;
      win_cnt <= 3'h0;
      op_rww  <= 1'b0;
      op_lock <= 1'b0;
    end else begin
      case (state)
        spm_ctrl_pkg::ST_IDLE: begin
          win_cnt <= 3'h0;
          if (cmd_ok) begin
            cmd   <= {w_data[4], w_data[3:1], 1'b1};
            state <= spm_ctrl_pkg::ST_ARMED;
          end
        end
        spm_ctrl_pkg::ST_ARMED: begin
          win_cnt <= win_cnt + 3'h1;
          if (lpm_fuse) begin
            cmd   <= 5'h00;
            state <= spm_ctrl_pkg::ST_IDLE;
          end else if (spm_hit && (is_erase || is_write || is_lock)) begin
            op_rww  <= page_op && in_rww;
            op_lock <= is_lock;
            state   <= spm_ctrl_pkg::ST_BUSY;
          end else if (spm_hit || win_end) begin
            cmd   <= 5'h00;
            state <= spm_ctrl_pkg::ST_IDLE;
          end
        end
        spm_ctrl_pkg::ST_BUSY: begin
          if (prog_done) begin
            cmd     <= 5'h00;
            op_rww  <= 1'b0;
            op_lock <= 1'b0;
            state   <= spm_ctrl_pkg::ST_IDLE;
          end
        end
        default: state <= spm_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // Lock bits: latch data at store, apply at completion; address unused
  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lock_pend <= 8'hff;
    end else if (spm_hit && is_lock) begin
      lock_pend <= {2'b11, data_low_i[5:0]};
    end
  end

  // Non-volatile bytes: one programs to zero only, reset values reload on rst_n_i
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_bits <= spm_ctrl_pkg::LOCK_RST;
      fuse_low  <= spm_ctrl_pkg::FLOW_RST;
      fuse_high <= spm_ctrl_pkg::FHIGH_RST;
      fuse_ext  <= spm_ctrl_pkg::FEXT_RST;
    end else if (prog_done && op_lock) begin
      lock_bits <= lock_bits & lock_pend;
    end
  end

  // Busy flag: set wins over re-enable clear
  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rww_busy <= 1'b0;
    end else if (page_op && in_rww) begin
      rww_busy <= 1'b1;
    end else if (spm_hit && is_rwwre && !prog_run) begin
      rww_busy <= 1'b0;
    end
  end

  // Flash side outputs
  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      erase_start_o <= 1'b0;
      write_start_o <= 1'b0;
      page_addr_o   <= 16'h0000;
      rww_block_o   <= 1'b0;
      flash_busy_o  <= 1'b0;
      load_data_o   <= 8'h00;
      load_valid_o  <= 1'b0;
    end else begin
      erase_start_o <= page_op && is_erase;
      write_start_o <= page_op && is_write;
      if (page_op) page_addr_o <= addr_ptr_i;
      rww_block_o   <= rww_busy || (page_op && in_rww);
      flash_busy_o  <= prog_run || prog_load;
      load_valid_o  <= load_prog_i;
      load_data_o   <= lpm_fuse ? fuse_sel : flash_byte_i;
    end
  end

  // AXI write path
  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // AXI read path
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      spm_ctrl_pkg::CTRL_OFFS:  rd_byte = {1'b0, rww_busy, 1'b0, cmd};
      spm_ctrl_pkg::LOCK_OFFS:  rd_byte = lock_bits;
      spm_ctrl_pkg::FLOW_OFFS:  rd_byte = fuse_low;
      spm_ctrl_pkg::FHIGH_OFFS: rd_byte = fuse_high;
      spm_ctrl_pkg::FEXT_OFFS:  rd_byte = fuse_ext;
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end
  always_ff @(posedge mclk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h0, rd_byte};
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Assertions
  a_rww_blocked: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    page_op && in_rww |=> ##1 rww_block_o) else $error("rww not blocked");
  a_busy_held: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    rww_busy && !(spm_hit && is_rwwre) |=> rww_busy) else $error("busy dropped");
  a_window_end: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    $rose(armed) |-> ##[1:4] !armed) else $error("window overran");
  a_timeout_clear: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    win_end && !spm_hit && !lpm_fuse |=> cmd == 5'h00) else $error("no auto clear");
  a_lock_timeout: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    win_end && is_lock && !spm_hit |=> !prog_run && $stable(lock_bits)) else $error("lock changed");
  a_ee_reject: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    ee_busy |-> !prog_load && !lpm_fuse) else $error("eeprom interlock");
  a_normal_read: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    load_prog_i && cmd == 5'h00 |=> load_data_o == $past(flash_byte_i)) else $error("bad read");
  a_ext_fuse: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    lpm_fuse && addr_ptr_i == spm_ctrl_pkg::Z_FEXT |=> load_data_o[7:3] == 5'h1f) else $error("ext fuse");
  a_lock_read: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    lpm_fuse && addr_ptr_i == spm_ctrl_pkg::Z_LOCK |=> load_data_o == lock_bits) else $error("lock read");
  a_no_rww_lock: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
    op_lock |-> !op_rww) else $error("lock blocked rww");
  c_erase: cover property (@(posedge mclk_i) disable iff (!rst_sync_n) page_op && is_erase);
  c_lock_set: cover property (@(posedge mclk_i) disable iff (!rst_sync_n) prog_done && op_lock);
  c_fuse_read: cover property (@(posedge mclk_i) disable iff (!rst_sync_n) lpm_fuse);
endmodule : spm_ctrl

//--- rtl/spm_ctrl_pkg.sv
// Package: register map, field positions, reset values and timing for the
// self-programming control block. Assumes a 125 MHz system clock.
package spm_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFS  = 8'h00; // prog_mem_ctrl_status
  localparam logic [7:0] LOCK_OFFS  = 8'h04; // Lock byte state
  localparam logic [7:0] FLOW_OFFS  = 8'h08; // Fuse low byte
  localparam logic [7:0] FHIGH_OFFS = 8'h0c; // Fuse high byte
  localparam logic [7:0] FEXT_OFFS  = 8'h10; // Extended fuse byte
  // Field positions of prog_mem_ctrl_status
  localparam int ENABLE_BIT   = 0;
  localparam int ERASE_BIT    = 1;
  localparam int WRITE_BIT    = 2;
  localparam int LOCKSET_BIT  = 3;
  localparam int REENABLE_BIT = 4;
  localparam int BUSY_BIT     = 6;
  // Reset values
  localparam logic [7:0] LOCK_RST  = 8'hff;
  localparam logic [7:0] FLOW_RST  = 8'h62;
  localparam logic [7:0] FHIGH_RST = 8'h99;
  localparam logic [7:0] FEXT_RST  = 8'hff;
  // Z pointer selectors for the timed read window
  localparam logic [15:0] Z_FLOW  = 16'h0000;
  localparam logic [15:0] Z_LOCK  = 16'h0001;
  localparam logic [15:0] Z_FEXT  = 16'h0002;
  localparam logic [15:0] Z_FHIGH = 16'h0003;
  // Read-while-write section limit (word address)
  localparam logic [15:0] RWW_LIMIT = 16'h3800;
  // Timing
  localparam int CLK_MHZ      = 125;
  localparam int SPM_WIN_CYC  = 4;
  localparam int LPM_WIN_CYC  = 3;
  localparam int PROG_MIN_US  = 3700;
  localparam int PROG_MAX_US  = 4500;
  // Min rounds up, max rounds down; target the midpoint
  localparam int PROG_MIN_CYC = PROG_MIN_US * CLK_MHZ;
  localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
  localparam int PROG_CYC     = (PROG_MIN_CYC + PROG_MAX_CYC) / 2;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} seq_state_e;
endpackage : spm_ctrl_pkg

//--- rtl/spm_window_timer.sv
// Holds a countdown timer used for the programming time.
// Assumes a synchronous load pulse on the same clock.
`timescale 1ns/1ps
module spm_window_timer #(
  parameter int WIDTH = 20
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  done_o,
  output logic                  running_o
);
  logic [WIDTH-1:0] remain;

  // Countdown, reload wins over decrement
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= '0;
    end else if (load_i) begin
      remain <= count_i;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  assign running_o = (remain != '0);
  assign done_o    = (remain == {{(WIDTH-1){1'b0}}, 1'b1}) && !load_i;
endmodule : spm_window_timer

//--- bench/cpu_core_model.sv
// CPU core model: moves the pointer and data byte, pulses store and load.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic        mclk_i,
  input  wire logic        load_valid_i,
  input  wire logic [7:0]  load_data_i,
  output logic             store_prog_o,
  output logic             load_prog_o,
  output logic [15:0]      addr_ptr_o,
  output logic [7:0]       data_low_o,
  output logic [7:0]       flash_byte_o
);
  logic [7:0] got;
  int         n_load;
  initial begin
    {store_prog_o, load_prog_o, addr_ptr_o, data_low_o, got} = '0;
  end
  // Normal flash content, a fixed scramble of the pointer
  assign flash_byte_o = addr_ptr_o[7:0] ^ 8'h3c;
  // Destination register of a load
  always @(posedge mclk_i) begin
    if (load_valid_i) begin
      got    <= load_data_i;
      n_load <= n_load + 1;
    end
  end
  // Pointer and data move only between commands
  task automatic prep(input logic [15:0] z, input logic [7:0] d);
    @(posedge mclk_i);
    addr_ptr_o <= z;
    data_low_o <= d;
  endtask : prep
  // One instruction after dly cycles
  task automatic pulse(input logic is_load, input int dly);
    repeat (dly) @(posedge mclk_i);
    if (is_load) load_prog_o <= 1'b1;
    else store_prog_o <= 1'b1;
    @(posedge mclk_i);
    load_prog_o  <= 1'b0;
    store_prog_o <= 1'b0;
  endtask : pulse
endmodule : cpu_core_model

//--- bench/tb_self_program_lock_fuse_ctrl.sv
// Testbench: AXI4-Lite master and CPU model around the sequencer.
// Assumes a 125 MHz clock; programming runs are shortened to 2000 cycles.
`timescale 1ns/1ps
module tb_self_program_lock_fuse_ctrl;
  localparam int PROG  = 2000;
  localparam int LIMIT = 40000;
  logic        mclk_i, rst_n_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ee_busy, load_valid, rww_block;
  logic        store_prog, load_prog, erase_start, write_start, flash_busy;
  logic [7:0]  awaddr, araddr, data_low, flash_byte, load_data;
  logic [7:0]  lock_exp = spm_ctrl_pkg::LOCK_RST;
  logic [31:0] wdata, rdata;
  logic [31:0] seed = 32'ha;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] addr_ptr, page_addr;
  int          fail_count, samples_checked, cyc, n_erase, n_write, busy_len;

  spm_ctrl #(.PROG_CYCLES(PROG)) dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .store_prog_i(store_prog), .load_prog_i(load_prog), .addr_ptr_i(addr_ptr),
    .data_low_i(data_low), .flash_byte_i(flash_byte), .eeprom_write_busy_i(ee_busy),
    .load_data_o(load_data), .load_valid_o(load_valid), .rww_block_o(rww_block),
    .erase_start_o(erase_start), .write_start_o(write_start), .page_addr_o(page_addr),
    .flash_busy_o(flash_busy));

  cpu_core_model cpu (
    .mclk_i(mclk_i), .load_valid_i(load_valid), .load_data_i(load_data),
    .store_prog_o(store_prog), .load_prog_o(load_prog), .addr_ptr_o(addr_ptr),
    .data_low_o(data_low), .flash_byte_o(flash_byte));

  // Clock, 8 ns period
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // Start pulses, busy cycles and hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (erase_start) n_erase <= n_erase + 1;
    if (write_start) n_write <= n_write + 1;
    if (flash_busy) busy_len <= busy_len + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Byte a timed-window load should return
  function automatic logic [7:0] exp_byte(input logic [15:0] z);
    case (z)
      spm_ctrl_pkg::Z_FLOW:  return spm_ctrl_pkg::FLOW_RST;
      spm_ctrl_pkg::Z_FHIGH: return spm_ctrl_pkg::FHIGH_RST;
      spm_ctrl_pkg::Z_FEXT:  return spm_ctrl_pkg::FEXT_RST & 8'h07;
      default:               return lock_exp;
    endcase
  endfunction : exp_byte

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] e);
    int n;
    @(posedge mclk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && n < 50);
    e = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] r, output logic [1:0] e);
    int n;
    @(posedge mclk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && n < 50);
    r = rdata;
    e = rresp;
    rready <= 1'b0;
  endtask : axr

  // Waits for the previous command to finish, then writes control
  task automatic cmd(input logic [7:0] v);
    logic [31:0] r;
    logic [1:0]  e;
    int          n;
    r = 32'h1;
    for (n = 0; n < 200 && r[0] !== 1'b0; n++) axr(spm_ctrl_pkg::CTRL_OFFS, r, e);
    axw(spm_ctrl_pkg::CTRL_OFFS, {24'h0, v}, e);
  endtask : cmd

  // Control write then a load after dly cycles
  task automatic lread(input logic [15:0] z, input logic [7:0] c, input int dly, output logic [7:0] v);
    int n0;
    cpu.prep(z, 8'hff);
    cmd(c);
    n0 = cpu.n_load;
    cpu.pulse(1'b1, dly);
    repeat (4) @(posedge mclk_i);
    chk(cpu.n_load - n0, 1);
    v = cpu.got;
  endtask : lread

  // Waits out a programming run, returns the busy cycles counted from the call on
  task automatic wait_done(output int dur);
    int n;
    int b;
    b = busy_len;
    for (n = 0; n < 600000 && flash_busy !== 1'b0; n++) @(posedge mclk_i);
    @(posedge mclk_i);
    dur = busy_len - b;
  endtask : wait_done

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  initial begin
    logic [31:0] r;
    logic [1:0]  e;
    logic [7:0]  v;
    logic [7:0]  d;
    logic [15:0] z;
    int          k;
    int          b0;
    int          bs;
    rst_n_i = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, ee_busy} = '0;
    wstrb = 4'hf;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    // Reset values and an unmapped offset
    axr(spm_ctrl_pkg::CTRL_OFFS, r, e);
    chk(r, 32'h0);
    for (k = 0; k < 4; k++) begin
      axr(spm_ctrl_pkg::LOCK_OFFS + 8'(4 * k), r, e);
      chk(r[7:0] & (k == 3 ? 8'h07 : 8'hff), exp_byte(16'(k == 0 ? 1 : k == 1 ? 0 : k == 2 ? 3 : 2)));
    end
    axr(8'h14, r, e);
    chk(e, 2'b10);
    $display("test regs done");
    // Every selector inside the window, then auto-clear
    for (k = 0; k < 4; k++) begin
      lread(16'(k), 8'h09, 0, v);
      chk(v & (k == 2 ? 8'h07 : 8'hff), exp_byte(16'(k)));
      axr(spm_ctrl_pkg::CTRL_OFFS, r, e);
      chk(r & 32'h9, 32'h0);
    end
    // Late load and a plain load give flash bytes
    lread(spm_ctrl_pkg::Z_LOCK, 8'h09, 5, v);
    chk(v, spm_ctrl_pkg::Z_LOCK[7:0] ^ 8'h3c);
    r = xs();
    lread(r[15:0], 8'h00, 0, v);
    chk(v, r[7:0] ^ 8'h3c);
    // Lock-set window runs out
    cpu.prep(spm_ctrl_pkg::Z_LOCK, 8'hc0);
    cmd(8'h09);
    cpu.pulse(1'b0, 6);
    repeat (4) @(posedge mclk_i);
    chk(flash_busy, 1'b0);
    axr(spm_ctrl_pkg::LOCK_OFFS, r, e);
    chk(r[7:0], lock_exp);
    $display("test window done");
    // EEPROM write in progress
    ee_busy <= 1'b1;
    repeat (4) @(posedge mclk_i);
    b0 = n_erase;
    cmd(8'h03);
    cpu.pulse(1'b0, 0);
    repeat (4) @(posedge mclk_i);
    chk(n_erase - b0, 0);
    lread(spm_ctrl_pkg::Z_FLOW, 8'h09, 0, v);
    chk(v, spm_ctrl_pkg::Z_FLOW[7:0] ^ 8'h3c);
    ee_busy <= 1'b0;
    repeat (4) @(posedge mclk_i);
    $display("test eeprom done");
    // Page erase inside the read-while-write section
    r = xs();
    z = 16'(r % 32'h7000) & 16'hff80;
    cpu.prep(z, 8'hff);
    b0 = n_erase;
    cmd(8'h03);
    bs = busy_len;
    cpu.pulse(1'b0, 0);
    repeat (3) @(posedge mclk_i);
    chk(n_erase - b0, 1);
    chk(page_addr, z);
    chk(rww_block, 1'b1);
    axr(spm_ctrl_pkg::CTRL_OFFS, r, e);
    chk(r & 32'h41, 32'h41);
    wait_done(k);
    chk(busy_len - bs, PROG + 1);
    chk(spm_ctrl_pkg::PROG_CYC >= spm_ctrl_pkg::PROG_MIN_CYC && spm_ctrl_pkg::PROG_CYC <= spm_ctrl_pkg::PROG_MAX_CYC, 1);
    chk(rww_block, 1'b1);
    cmd(8'h11);
    cpu.pulse(1'b0, 0);
    repeat (4) @(posedge mclk_i);
    chk(rww_block, 1'b0);
    axr(spm_ctrl_pkg::CTRL_OFFS, r, e);
    chk(r[6], 1'b0);
    $display("test erase done");
    // Lock set with a random pointer
    r = xs();
    d = {2'b11, r[5:0]};
    cpu.prep(r[31:16], d);
    cmd(8'h09);
    cpu.pulse(1'b0, 0);
    repeat (3) @(posedge mclk_i);
    chk(flash_busy, 1'b1);
    chk(rww_block, 1'b0);
    wait_done(k);
    lock_exp = lock_exp & d;
    axr(spm_ctrl_pkg::LOCK_OFFS, r, e);
    chk(r[7:0], lock_exp);
    lread(spm_ctrl_pkg::Z_LOCK, 8'h09, 0, v);
    chk(v, lock_exp);
    $display("test lock done");
    // Page write in the other section
    r = xs();
    cpu.prep(16'h7000 | (r[15:0] & 16'h0f80), 8'hff);
    b0 = n_write;
    cmd(8'h05);
    cpu.pulse(1'b0, 0);
    repeat (3) @(posedge mclk_i);
    chk(n_write - b0, 1);
    chk(rww_block, 1'b0);
    chk(flash_busy, 1'b1);
    $display("test write done");
    conclude();
  end
endmodule : tb_self_program_lock_fuse_ctrl
